// ==== common/ebi_pkg.sv ====
// constants shared by the external bus interface files.
// assumes a 32-bit apb with byte addressing; registers sit at index times four.
package ebi_pkg;

  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_BUS_TIMING_LOW = 12'h468;
  localparam logic [11:0] IDX_BUS_TIMING_HIGH = 12'h469;
  localparam logic [11:0] IDX_BUS_CONFIGURATION = 12'h46A;
  localparam logic [11:0] IDX_BUS_STATUS = 12'h46B;
  localparam logic [15:0] ADDR_BUS_TIMING_LOW = 16'({IDX_BUS_TIMING_LOW, 2'b00});
  localparam logic [15:0] ADDR_BUS_TIMING_HIGH = 16'({IDX_BUS_TIMING_HIGH, 2'b00});
  localparam logic [15:0] ADDR_BUS_CONFIGURATION = 16'({IDX_BUS_CONFIGURATION, 2'b00});
  localparam logic [15:0] ADDR_BUS_STATUS = 16'({IDX_BUS_STATUS, 2'b00});

  // values after reset
  localparam logic [7:0] RST_BUS_TIMING_LOW = 8'hEF;
  localparam logic [7:0] RST_BUS_TIMING_HIGH = 8'hFF;
  localparam logic [7:0] RST_BUS_CONFIGURATION = 8'h00;

  // bus_timing_high field positions
  localparam int unsigned WRITE_DATA_TIME_LSB = 6;
  localparam int unsigned WRITE_ADDR_TIME_LSB = 4;
  localparam int unsigned READ_DATA_TIME_LSB = 2;
  localparam int unsigned READ_ADDR_TIME_LSB = 0;
  // bus_timing_low field positions
  localparam int unsigned STROBE_WIDTH_LSB = 6;
  localparam int unsigned LATCH_PULSE_WIDTH_BIT = 5;
  localparam int unsigned UNUSED_LOW_BIT = 4;
  localparam int unsigned CODE_READ_TIME_LSB = 2;
  localparam int unsigned CODE_ADDR_TIME_LSB = 0;
  // bus_configuration field positions
  localparam int unsigned STALL_INPUT_CONTROL_BIT = 4;
  localparam int unsigned BUS_CONTROL_BIT = 3;
  localparam int unsigned BUS_CONFIG_CODE_LSB = 0;
  localparam logic [7:0] BUS_CONFIGURATION_MASK = 8'h1F;
  // bus configuration codes loaded from the width strap
  localparam logic [2:0] BC_BUS_8 = 3'h2;
  localparam logic [2:0] BC_BUS_16 = 3'h3;
  // bus_status bit positions
  localparam int unsigned STAT_CODE_SOURCE_BIT = 0;
  localparam int unsigned STAT_BUS_WIDTH_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_STALL_BIT = 3;

  // internal program memory size, 32 kbytes
  localparam logic [19:0] INT_CODE_LIMIT = 20'h08000;

  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_ADDR, ST_STROBE, ST_HOLD} ebi_state_e;
  typedef enum logic [1:0] {K_CODE, K_READ, K_WRITE} ebi_kind_e;

endpackage : ebi_pkg

// ==== hw/ebi_regs.sv ====
// apb slave holding the bus timing and configuration registers.
// assumes apb3/apb4 master; answers with no wait states, errors on unmapped.
module ebi_regs (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_strap_load,
  input wire logic i_width_strap,
  input wire logic [7:0] i_status,
  output logic [7:0] o_timing_low,
  output logic [7:0] o_timing_high,
  output logic [7:0] o_config
);

  typedef struct packed {
    logic [7:0] bus_timing_low;
    logic [7:0] bus_timing_high;
    logic [7:0] bus_configuration;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ebi_regs_s;

  ebi_regs_s s_q;
  ebi_regs_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // default bus width follows the strap
    if (i_strap_load) begin
      s_d.bus_configuration[ebi_pkg::BUS_CONFIG_CODE_LSB +: 3] = i_width_strap ? ebi_pkg::BC_BUS_16
                                                                 : ebi_pkg::BC_BUS_8;
    end
    // setup phase: decode and prepare the answer
    if (i_psel && !i_penable) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      case (i_paddr)
        ebi_pkg::ADDR_BUS_TIMING_LOW: s_d.prdata[7:0] = s_q.bus_timing_low;
        ebi_pkg::ADDR_BUS_TIMING_HIGH: s_d.prdata[7:0] = s_q.bus_timing_high;
        ebi_pkg::ADDR_BUS_CONFIGURATION: s_d.prdata[7:0] = s_q.bus_configuration;
        ebi_pkg::ADDR_BUS_STATUS: s_d.prdata[7:0] = i_status;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    // write lands on the access edge only; status is read only
    if (i_psel && i_penable && s_q.pready && i_pwrite && i_pstrb[0]) begin
      case (i_paddr)
        ebi_pkg::ADDR_BUS_TIMING_LOW: begin
          s_d.bus_timing_low = i_pwdata[7:0];
          s_d.bus_timing_low[ebi_pkg::UNUSED_LOW_BIT] = 1'b0;
        end
        ebi_pkg::ADDR_BUS_TIMING_HIGH: s_d.bus_timing_high = i_pwdata[7:0];
        ebi_pkg::ADDR_BUS_CONFIGURATION: s_d.bus_configuration = i_pwdata[7:0] & ebi_pkg::BUS_CONFIGURATION_MASK;
        default: s_d.bus_timing_low = s_d.bus_timing_low;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.bus_timing_low <= ebi_pkg::RST_BUS_TIMING_LOW;
      s_q.bus_timing_high <= ebi_pkg::RST_BUS_TIMING_HIGH;
      s_q.bus_configuration <= ebi_pkg::RST_BUS_CONFIGURATION;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_timing_low = s_q.bus_timing_low;
  assign o_timing_high = s_q.bus_timing_high;
  assign o_config = s_q.bus_configuration;

endmodule : ebi_regs

// ==== hw/ebi_strap.sv ====
// strap capture for the code source and bus width pins.
// assumes straps are stable across the release of the asynchronous reset.
module ebi_strap (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_code_pin,
  input wire logic i_width_pin,
  output logic o_code_source,
  output logic o_bus_width,
  output logic o_done,
  output logic o_load
);

  typedef struct packed {
    logic done;
    logic load;
    logic code;
    logic width;
  } ebi_strap_s;

  ebi_strap_s s_q;
  ebi_strap_s s_d;

  // pins are caught at the first edge after release, never under reset; held until reset
  always_comb begin
    s_d = s_q;
    s_d.load = 1'b0;
    if (!s_q.done) begin
      s_d.code = i_code_pin;
      s_d.width = i_width_pin;
      s_d.done = 1'b1;
      s_d.load = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_code_source = s_q.code;
  assign o_bus_width = s_q.width;
  assign o_done = s_q.done;
  assign o_load = s_q.load;

endmodule : ebi_strap

// ==== hw/ebi_top.sv ====
// external bus interface: code and data cycles on a multiplexed bus.
// assumes pins synchronous to i_sys_clk; internal program memory outside.
//
// How it works
// - program fetch strobe goes low during every external code fetch.
// - program fetch strobe stays high except during external code fetches.
// - code source strap caught at reset release and held until next reset.
// - captured zero sends every code fetch to external memory.
// - captured one keeps code below internal size internal, at or above goes external.
// - after capture the code source pin acts as stall request.
// - stall high during the strobe phase of an external access stretches it until released.
// - bus_timing_high holds write, read data and address timings, resets FF.
// - bus_timing_low holds strobe width, latch width, code timings, resets EF.
// - address latch strobe pulses high only during a bus cycle.
// - bus width strap caught at release picks 8-bit or 16-bit default.
// - separate active-low read strobe for external data reads.
module ebi_top (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_req,
  input wire logic i_req_code,
  input wire logic i_req_write,
  input wire logic i_req_word,
  input wire logic [19:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  output logic o_ack,
  output logic o_ack_internal,
  output logic [15:0] o_rdata,
  output logic o_busy,
  input wire logic i_code_source_strap,
  input wire logic i_bus_width_strap,
  output logic o_ale,
  output logic o_program_fetch_strobe_n,
  output logic o_read_strobe_n,
  output logic o_low_byte_write_strobe_n,
  output logic o_high_byte_write_strobe_n,
  output logic [3:0] o_addr_hi,
  output logic [15:0] o_ad_out,
  output logic o_ad_oe,
  input wire logic [15:0] i_ad_in
);

  typedef struct packed {
    ebi_pkg::ebi_state_e state;
    logic [2:0] cnt;
    ebi_pkg::ebi_kind_e kind;
    logic word;
    logic second;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic ack_int;
    logic busy;
    logic ale;
    logic pfs_n;
    logic rd_n;
    logic wrl_n;
    logic wrh_n;
    logic [15:0] ad_out;
    logic ad_oe;
    logic [3:0] addr_hi;
  } ebi_core_s;

  ebi_core_s s_q;
  ebi_core_s s_d;

  logic code_source;
  logic bus_width;
  logic strap_done;
  logic strap_load;
  logic [7:0] bus_timing_low;
  logic [7:0] bus_timing_high;
  logic [7:0] bus_configuration;
  logic [7:0] status;

  ebi_strap u_strap (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_code_pin(i_code_source_strap),
    .i_width_pin(i_bus_width_strap),
    .o_code_source(code_source),
    .o_bus_width(bus_width),
    .o_done(strap_done),
    .o_load(strap_load)
  );

  ebi_regs u_regs (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_strap_load(strap_load),
    .i_width_strap(bus_width), // captured copy, the pin may move after release
    .i_status(status),
    .o_timing_low(bus_timing_low),
    .o_timing_high(bus_timing_high),
    .o_config(bus_configuration)
  );

  // address or data phase length for the access kind
  function automatic logic [1:0] phase_time(ebi_pkg::ebi_kind_e k, logic [7:0] lo,
                                            logic [7:0] hi, logic data);
    logic [1:0] t;
    case (k)
      ebi_pkg::K_CODE: t = data ? lo[ebi_pkg::CODE_READ_TIME_LSB +: 2]
                                : lo[ebi_pkg::CODE_ADDR_TIME_LSB +: 2];
      ebi_pkg::K_READ: t = data ? hi[ebi_pkg::READ_DATA_TIME_LSB +: 2]
                                : hi[ebi_pkg::READ_ADDR_TIME_LSB +: 2];
      default: t = data ? hi[ebi_pkg::WRITE_DATA_TIME_LSB +: 2]
                        : hi[ebi_pkg::WRITE_ADDR_TIME_LSB +: 2];
    endcase
    return t;
  endfunction : phase_time

  logic bus16;
  logic stall;
  logic go;
  logic [19:0] go_addr;
  logic enter_strobe;
  logic finish;
  logic [1:0] hold_time;

  // code source pin doubles as stall once the strap is taken
  assign bus16 = (bus_configuration[ebi_pkg::BUS_CONFIG_CODE_LSB +: 3] == ebi_pkg::BC_BUS_16);
  assign stall = strap_done && i_code_source_strap && !bus_configuration[ebi_pkg::STALL_INPUT_CONTROL_BIT];
  assign hold_time = bus_timing_low[ebi_pkg::STROBE_WIDTH_LSB +: 2];

  always_comb begin
    status = 8'h00;
    status[ebi_pkg::STAT_CODE_SOURCE_BIT] = code_source;
    status[ebi_pkg::STAT_BUS_WIDTH_BIT] = bus_width;
    status[ebi_pkg::STAT_BUSY_BIT] = s_q.busy;
    status[ebi_pkg::STAT_STALL_BIT] = stall;
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.ack_int = 1'b0;
    go = 1'b0;
    go_addr = s_q.addr;
    enter_strobe = 1'b0;
    finish = 1'b0;
    case (s_q.state)
      ebi_pkg::ST_IDLE: begin
        if (strap_done && i_req) begin
          s_d.addr = i_req_addr;
          s_d.wdata = i_req_wdata;
          s_d.word = i_req_word || i_req_code;
          s_d.second = 1'b0;
          s_d.rdata = 16'h0000;
          if (i_req_code) begin
            s_d.kind = ebi_pkg::K_CODE;
          end else if (i_req_write) begin
            s_d.kind = ebi_pkg::K_WRITE;
          end else begin
            s_d.kind = ebi_pkg::K_READ;
          end
          // strap low forces all code external; high keeps the low part inside
          if (i_req_code && code_source && (i_req_addr < ebi_pkg::INT_CODE_LIMIT)) begin
            s_d.ack = 1'b1;
            s_d.ack_int = 1'b1;
          end else begin
            go = 1'b1;
            go_addr = i_req_addr;
          end
        end
      end
      ebi_pkg::ST_ALE: begin
        if (s_q.cnt != 3'h0) begin
          s_d.cnt = s_q.cnt - 3'h1;
        end else begin
          s_d.ale = 1'b0;
          if (phase_time(s_q.kind, bus_timing_low, bus_timing_high, 1'b0) == 2'h0) begin
            enter_strobe = 1'b1;
          end else begin
            s_d.state = ebi_pkg::ST_ADDR;
            s_d.cnt = {1'b0, phase_time(s_q.kind, bus_timing_low, bus_timing_high, 1'b0) - 2'h1};
          end
        end
      end
      ebi_pkg::ST_ADDR: begin
        if (s_q.cnt != 3'h0) begin
          s_d.cnt = s_q.cnt - 3'h1;
        end else begin
          enter_strobe = 1'b1;
        end
      end
      ebi_pkg::ST_STROBE: begin
        // stall sampled each edge; each high sample adds one clock
        if (stall) begin
          s_d.cnt = s_q.cnt;
        end else if (s_q.cnt != 3'h0) begin
          s_d.cnt = s_q.cnt - 3'h1;
        end else begin
          s_d.pfs_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.wrl_n = 1'b1;
          s_d.wrh_n = 1'b1;
          if (s_q.kind != ebi_pkg::K_WRITE) begin
            if (!bus16) begin
              if (s_q.second) begin
                s_d.rdata[15:8] = i_ad_in[7:0];
              end else begin
                s_d.rdata[7:0] = i_ad_in[7:0];
              end
            end else if (s_q.word) begin
              s_d.rdata = i_ad_in;
            end else if (s_q.addr[0]) begin
              s_d.rdata = {8'h00, i_ad_in[15:8]};
            end else begin
              s_d.rdata = {8'h00, i_ad_in[7:0]};
            end
          end
          if (hold_time == 2'h0) begin
            finish = 1'b1;
          end else begin
            s_d.state = ebi_pkg::ST_HOLD;
            s_d.cnt = {1'b0, hold_time - 2'h1};
          end
        end
      end
      ebi_pkg::ST_HOLD: begin
        if (s_q.cnt != 3'h0) begin
          s_d.cnt = s_q.cnt - 3'h1;
        end else begin
          finish = 1'b1;
        end
      end
      default: begin
        s_d.state = ebi_pkg::ST_IDLE;
      end
    endcase

    // strobe phase: only the strobe of this access kind falls
    if (enter_strobe) begin
      s_d.state = ebi_pkg::ST_STROBE;
      s_d.cnt = {1'b0, phase_time(s_q.kind, bus_timing_low, bus_timing_high, 1'b1)};
      case (s_q.kind)
        ebi_pkg::K_CODE: begin
          s_d.pfs_n = 1'b0;
          s_d.ad_oe = 1'b0;
        end
        ebi_pkg::K_READ: begin
          s_d.rd_n = 1'b0;
          s_d.ad_oe = 1'b0;
        end
        default: begin
          s_d.ad_oe = 1'b1;
          if (!bus16) begin
            s_d.wrl_n = 1'b0;
            s_d.ad_out = {8'h00, s_q.second ? s_q.wdata[15:8] : s_q.wdata[7:0]};
          end else if (s_q.word) begin
            s_d.wrl_n = 1'b0;
            s_d.wrh_n = 1'b0;
            s_d.ad_out = s_q.wdata;
          end else if (s_q.addr[0]) begin
            s_d.wrh_n = 1'b0;
            s_d.ad_out = {s_q.wdata[7:0], 8'h00};
          end else begin
            s_d.wrl_n = 1'b0;
            s_d.ad_out = {8'h00, s_q.wdata[7:0]};
          end
        end
      endcase
    end

    // an 8-bit bus splits a word into two byte cycles, low byte first
    if (finish) begin
      s_d.ad_oe = 1'b0;
      if (!bus16 && s_q.word && !s_q.second) begin
        s_d.second = 1'b1;
        go = 1'b1;
        go_addr = s_q.addr + 20'h00001;
      end else begin
        s_d.state = ebi_pkg::ST_IDLE;
        s_d.ack = 1'b1;
      end
    end

    // address phase on the multiplexed lines with the latch pulse
    if (go) begin
      s_d.state = ebi_pkg::ST_ALE;
      s_d.cnt = {2'b00, bus_timing_low[ebi_pkg::LATCH_PULSE_WIDTH_BIT]};
      s_d.ale = 1'b1;
      s_d.ad_out = go_addr[15:0];
      s_d.ad_oe = 1'b1;
      s_d.addr_hi = go_addr[19:16];
    end

    s_d.busy = (s_d.state != ebi_pkg::ST_IDLE);
  end

  // active-low strobes idle high out of reset; the latch strobe idles low
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.state <= ebi_pkg::ST_IDLE;
      s_q.kind <= ebi_pkg::K_CODE;
      s_q.pfs_n <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.wrl_n <= 1'b1;
      s_q.wrh_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ack = s_q.ack;
  assign o_ack_internal = s_q.ack_int;
  assign o_rdata = s_q.rdata;
  assign o_busy = s_q.busy;
  assign o_ale = s_q.ale;
  assign o_program_fetch_strobe_n = s_q.pfs_n;
  assign o_read_strobe_n = s_q.rd_n;
  assign o_low_byte_write_strobe_n = s_q.wrl_n;
  assign o_high_byte_write_strobe_n = s_q.wrh_n;
  assign o_addr_hi = s_q.addr_hi;
  assign o_ad_out = s_q.ad_out;
  assign o_ad_oe = s_q.ad_oe;

endmodule : ebi_top

// ==== testbench/ebi_checker.sv ====
// pin and apb timing checks for ebi_top.
// bound into ebi_top; the bench never sets the stall disable bit.
module ebi_checker (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_code_source_strap,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_ack,
  input wire logic o_ack_internal,
  input wire logic o_busy,
  input wire logic o_ale,
  input wire logic o_program_fetch_strobe_n,
  input wire logic o_read_strobe_n,
  input wire logic o_ad_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  fetch_in_cycle_a: assert property (!o_program_fetch_strobe_n |-> o_busy && !o_ad_oe)
    else $error("fetch strobe outside a bus cycle");
  fetch_vs_read_a: assert property (!o_program_fetch_strobe_n |-> o_read_strobe_n)
    else $error("fetch and read strobes low together");
  ale_in_cycle_a: assert property (o_ale |-> o_busy && o_program_fetch_strobe_n)
    else $error("latch strobe outside address phase");
  ale_width_a: assert property ($rose(o_ale) |-> ##[1:2] !o_ale)
    else $error("latch strobe too long");
  stall_stretch_a: assert property (!(o_program_fetch_strobe_n && o_read_strobe_n) &&
    i_code_source_strap |=> $stable(o_program_fetch_strobe_n) && $stable(o_read_strobe_n))
    else $error("strobe ended under stall");
  internal_fetch_a: assert property (o_ack_internal |-> o_ack && !o_busy && !$past(o_busy))
    else $error("internal fetch used the bus");
  cycle_bound_a: assert property ($rose(o_busy) |-> ##[2:120] o_ack)
    else $error("bus cycle never acknowledged");
  read_bus_free_a: assert property (!o_read_strobe_n |-> o_busy && !o_ad_oe)
    else $error("bus driven during read strobe");
  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("apb answer missing");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  cover property (!o_read_strobe_n && i_code_source_strap);
  cover property (o_ack_internal);
  cover property (o_pslverr);
endmodule : ebi_checker

bind ebi_top ebi_checker u_check (.*);

// ==== testbench/ebi_mem_model.sv ====
// external memory on the multiplexed bus.
// latches the address on the latch strobe; releases the bus between reads.
module ebi_mem_model (
  input wire logic i_clk,
  input wire logic i_ale,
  input wire logic [15:0] i_ad,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  output logic [15:0] o_ad,
  output logic [15:0] o_last_write
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr_q = 16'h0000;
  logic [15:0] hold_q = 16'h0000;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat
  // released bus toggles so stale data can never look valid
  assign o_ad = i_oe_n ? ~hold_q : addr_q[0] ? {2{pat(addr_q)}} :
    {pat(addr_q | 16'h0001), pat(addr_q)};
  always @(posedge i_clk) begin
    hold_q <= o_ad;
    if (i_ale)
      addr_q <= i_ad;
    if (!i_we_n)
      o_last_write <= i_ad;
  end
endmodule : ebi_mem_model

// ==== testbench/ebi_top_test.sv ====
// bench for ebi_top: apb master, bus requester and reference model.
// needs ebi_pkg, the design, ebi_mem_model and ebi_checker.
module ebi_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, req = 1'b0, rc = 1'b0, rw = 1'b0, rwd = 1'b0;
  logic stall = 1'b0, wstrap = 1'b1, cs, w16;
  logic [15:0] paddr = 16'h0000, wd = 16'h0000, rdata, adout, adin, lastw;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [19:0] ra = 20'h0;
  logic [7:0] tl, th;
  logic [3:0] ahi, strb = 4'hF;
  logic pready, pslverr, ack, acki, busy, ale, pfs_n, rd_n, wl_n, wh_n;
  int failures = 0, num_checks = 0, cycles = 0, seed = 11;

  ebi_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_req(req), .i_req_code(rc), .i_req_write(rw),
    .i_req_word(rwd), .i_req_addr(ra), .i_req_wdata(wd), .o_ack(ack), .o_ack_internal(acki),
    .o_rdata(rdata), .o_busy(busy), .i_code_source_strap(stall), .i_bus_width_strap(wstrap),
    .o_ale(ale), .o_program_fetch_strobe_n(pfs_n), .o_read_strobe_n(rd_n),
    .o_low_byte_write_strobe_n(wl_n), .o_high_byte_write_strobe_n(wh_n), .o_addr_hi(ahi),
    .o_ad_out(adout), .o_ad_oe(), .i_ad_in(adin));
  ebi_mem_model mem (.i_clk(clk), .i_ale(ale), .i_ad(adout), .i_oe_n(pfs_n & rd_n),
    .i_we_n(wl_n & wh_n), .o_ad(adin), .o_last_write(lastw));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : pat

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    check(q, e);
    check(er, ee);
  endtask : rd

  task automatic acc(input logic c, input logic w, input logic word, input logic [19:0] a,
                     input int k);
    int n, t, p;
    logic in, f, r, l, g, h;
    logic [5:0] x;
    logic [15:0] e;
    t = 1 + tl[5] + (c ? tl[1:0] : w ? th[5:4] : th[1:0]);
    p = t + 1 + tl[7:6] + (c ? tl[3:2] : w ? th[7:6] : th[3:2]);
    in = c && cs && a < 20'h08000;
    e = {pat(a[15:0] + 16'h0001), pat(a[15:0])};
    @(posedge clk);
    req <= 1'b1;
    rc <= c;
    rw <= w;
    rwd <= word;
    ra <= a;
    wd <= a[15:0] ^ 16'hC33C;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    f = 0;
    r = 0;
    l = 0;
    g = 0;
    h = 0;
    do begin
      @(negedge clk);
      n++;
      f |= !pfs_n;
      r |= !rd_n;
      l |= ale;
      g |= !wl_n;
      h |= !wh_n;
      if (ack !== 1'b1) begin
        @(posedge clk);
        stall <= n >= t && n < t + k;
      end
    end while (ack !== 1'b1 && n < 200);
    check(n, in ? 1 : ((c || word) && !w16 ? 2 : 1) * p + k + 1);
    // a code request with the write flag set is still a fetch
    x = {in, c && !in, !c && !w, !in, !c && w && !(w16 && !word && a[0]),
         !c && w && w16 && (word || a[0])};
    check({acki, f, r, l, g, h}, x);
    if (!in)
      check(ahi, a[19:16]);
    if ((c || !w) && !in)
      check(c || word ? rdata : rdata[7:0], c || word ? e : e[7:0]);
    if (!c && w && word && w16)
      check(lastw, a[15:0] ^ 16'hC33C);
  endtask : acc

  task automatic run(input logic c, input logic w);
    logic [31:0] v;
    logic [31:0] q;
    logic er;
    @(posedge clk);
    stall <= 1'b0;
    wstrap <= ~w;
    cs = c;
    w16 = w;
    tl = ebi_pkg::RST_BUS_TIMING_LOW;
    th = ebi_pkg::RST_BUS_TIMING_HIGH;
    rd(ebi_pkg::ADDR_BUS_TIMING_LOW, tl, 1'b0);
    rd(ebi_pkg::ADDR_BUS_TIMING_HIGH, th, 1'b0);
    rd(ebi_pkg::ADDR_BUS_CONFIGURATION, w ? ebi_pkg::BC_BUS_16 : ebi_pkg::BC_BUS_8, 1'b0);
    rd(16'h11B0, 32'h0, 1'b1);
    acc(1'b1, 1'b0, 1'b1, 20'h00100, 0);
    acc(1'b1, 1'b0, 1'b1, 20'h08000, 2);
    acc(1'b0, 1'b0, 1'b1, 20'h00200, 1);
    acc(1'b0, 1'b0, 1'b0, 20'h00301, 0);
    acc(1'b0, 1'b1, 1'b1, 20'h00402, 3);
    v = $random(seed);
    tl = v[7:0];
    th = v[15:8];
    apb(1'b1, ebi_pkg::ADDR_BUS_TIMING_LOW, {24'h0, tl}, q, er);
    apb(1'b1, ebi_pkg::ADDR_BUS_TIMING_HIGH, {24'h0, th}, q, er);
    rd(ebi_pkg::ADDR_BUS_TIMING_LOW, tl & 8'hEF, 1'b0);
    // byte lane 0 off: the write must leave the register alone
    strb <= 4'hE;
    apb(1'b1, ebi_pkg::ADDR_BUS_TIMING_HIGH, ~{24'h0, th}, q, er);
    strb <= 4'hF;
    rd(ebi_pkg::ADDR_BUS_TIMING_HIGH, th, 1'b0);
    repeat (12) begin
      v = $random(seed);
      acc(v[0] & v[1], v[2], v[3], {3'h0, v[20:5], v[4] & ~v[3] & ~(v[0] & v[1])},
          v[26:24]);
    end
    rd(ebi_pkg::ADDR_BUS_STATUS, {30'h0, w, c}, 1'b0);
    $display("strap run %0d%0d done", c, w);
  endtask : run

  always @(posedge clk) begin
    cycles++;
    // far above the thousand or so cycles the runs need
    if (cycles == 8000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run(1'b0, 1'b1);
    rst <= 1'b1;
    stall <= 1'b1;
    wstrap <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run(1'b1, 1'b0);
    summarize();
  end
endmodule : ebi_top_test
